// ### inc/afmc_cfg.svh
// constants of the acquisition mode and multiplexer control block
`ifndef AFMC_CFG_SVH
`define AFMC_CFG_SVH
`define AFMC_SEL_MODE_BIT   4
`define AFMC_SEL_SWAP_BIT   3
`define AFMC_CFG5_BUSY_BIT  7
`define AFMC_CFG5_SEL_LSB   1
`define AFMC_CFG5_REF_BIT   0
`define AFMC_EN_MOD_BIT     0
`define AFMC_RESULT_RST     16'h0000
`define AFMC_CFG5_RST       8'h00
`define AFMC_START_READ     1'h0
`define AFMC_GAIN_ONE       4'h1
`define AFMC_GAIN_TWO       4'h2
`define AFMC_GAIN_FIVE      4'h5
`define AFMC_GAIN_TEN       4'hA
`define AFMC_OFF2_MAG_MAX   3'h5
`define AFMC_GAIN3_UNITY    7'h0C
`define AFMC_REF_PAIR_LOW_P 4'h2
`define AFMC_REF_PAIR_LOW_N 4'h1
`define AFMC_REF_PAIR_HI_P  4'h8
`define AFMC_REF_PAIR_HI_N  4'h4
`endif

// ### inc/afmc_pkg.sv
// types of the acquisition mode and multiplexer control block
package afmc_pkg;
  typedef enum logic [1:0] {
    AFMC_IDLE = 2'b01,
    AFMC_RUN  = 2'b10
  } afmc_state_t;

  typedef struct packed {
    logic [4:0] input_select_code;
    logic       reference_select_bit;
    logic [3:0] enable_field;
    logic       stage1_gain_bit;
    logic [1:0] stage2_gain_code;
    logic [3:0] stage2_offset_code;
    logic [6:0] stage3_gain_code;
    logic [6:0] stage3_offset_code;
  } afmc_cfg_t;

  typedef struct packed {
    logic [7:0] pos_line;
    logic [7:0] neg_line;
    logic [3:0] ref_pos;
    logic [3:0] ref_neg;
  } afmc_mux_t;

  typedef struct packed {
    logic              mod_enable;
    logic [2:0]        stage_bypass;
    logic [3:0]        gain1;
    logic [3:0]        gain2;
    logic signed [3:0] offset2_fifths;
    logic [6:0]        gain3_twelfths;
    logic signed [6:0] offset3_twelfths;
  } afmc_amp_t;
endpackage

// ### src/afmc_ctrl.sv
// acquisition mode sequencing and front-end multiplexer and amplifier decode
// Notes on behaviour
// (R1) one continuous-mode bit picks continuous or on-request operation
// (R2) continuous mode starts the next conversion right after the previous ends
// (R3) each finished conversion stores its result and pulses one completion trigger
// (R4) on-request mode starts only on the start bit, same sequence as continuous
// (R5) selector mode 0 forms pairs 1-0, 3-2, 5-4, 7-6 from the low two bits
// (R6) selector mode 1 takes the chosen input against input 0
// (R7) select bit 3 swaps positive and negative inputs
// (R8) select code sits at bits 5..1 of config word five, drives the mux
// (R9) reference bit 0 picks pair 1-0, 1 picks pair 3-2
// (R10) enable bit 0 runs the modulator, bits 1..3 the stages; off means bypass
// (R11) software should drop the modulator enable while idle to save power
// (R12) stage one gain bit gives gain 1 or 10
// (R13) stage two gain code gives 1, 2, 5, 10
// (R14) stage two offset is sign-magnitude in steps of 0.2, up to one
// (R15) stage three gain is the code over twelve
// (R16) stage three offset is sign-magnitude twelfths, both zero codes mean zero
// (R17) start reads as 0; a start during a conversion runs after it ends
// (R18) busy reads 1 while a conversion runs
// (R19) dropping continuous mode lets the running conversion finish and stop
`include "afmc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module afmc_ctrl (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic             cont_mode,
  input  wire logic             start_req,
  input  wire logic             conv_done,
  input  wire logic [15:0]      conv_data,
  input  wire afmc_pkg::afmc_cfg_t cfg,
  output logic                  conv_start,
  output logic                  done_trig,
  output logic                  busy,
  output logic [15:0]           result,
  output logic                  start_bit_readback,
  output logic [7:0]            acq_config_word_five,
  output afmc_pkg::afmc_mux_t   mux,
  output afmc_pkg::afmc_amp_t   amp
);

  afmc_pkg::afmc_state_t state_reg;
  afmc_pkg::afmc_state_t state_next;
  logic                  pend_reg;
  logic                  pend_next;
  logic                  go_reg;
  logic                  go_next;
  logic                  done_reg;
  logic                  done_next;
  logic                  busy_reg;
  logic                  busy_next;
  logic [15:0]           result_reg;
  logic [15:0]           result_next;
  logic                  start_rd_reg;
  logic [7:0]            cfg5_reg;
  logic [7:0]            cfg5_next;
  afmc_pkg::afmc_mux_t   mux_reg;
  afmc_pkg::afmc_mux_t   mux_next;
  afmc_pkg::afmc_amp_t   amp_reg;
  afmc_pkg::afmc_amp_t   amp_next;
  logic [2:0]            p_idx;
  logic [2:0]            n_idx;
  logic [7:0]            pos_vec;
  logic [7:0]            neg_vec;
  logic [2:0]            mag2;
  logic [3:0]            mag2_w;
  logic [6:0]            mag3_w;

  // conversion sequencer
  always_comb
  begin
    state_next  = state_reg;
    pend_next   = pend_reg | start_req; // see (R17)
    go_next     = 1'b0;
    done_next   = 1'b0;
    result_next = result_reg;
    unique case (state_reg)
      afmc_pkg::AFMC_IDLE:
      begin
        if (cont_mode || pend_next) // see (R1) see (R4)
        begin
          state_next = afmc_pkg::AFMC_RUN;
          go_next    = 1'b1;
          pend_next  = 1'b0;
        end
      end
      afmc_pkg::AFMC_RUN:
      begin
        if (conv_done)
        begin
          result_next = conv_data; // see (R3)
          done_next   = 1'b1;
          if (cont_mode || pend_next) // see (R2) see (R17)
          begin
            go_next   = 1'b1;
            pend_next = pend_reg & start_req; // see (R17)
          end
          else
          begin
            state_next = afmc_pkg::AFMC_IDLE; // see (R19)
          end
        end
      end
    endcase
    busy_next = (state_next == afmc_pkg::AFMC_RUN); // see (R18)
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg    <= afmc_pkg::AFMC_IDLE;
      pend_reg     <= 1'b0;
      go_reg       <= 1'b0;
      done_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      result_reg   <= `AFMC_RESULT_RST;
      start_rd_reg <= `AFMC_START_READ;
    end
    else if (clk_en)
    begin
      state_reg    <= state_next;
      pend_reg     <= pend_next;
      go_reg       <= go_next;
      done_reg     <= done_next;
      busy_reg     <= busy_next;
      result_reg   <= result_next;
      start_rd_reg <= `AFMC_START_READ; // see (R17)
    end
  end

  // input selector decode
  always_comb
  begin
    if (cfg.input_select_code[`AFMC_SEL_MODE_BIT])
    begin
      p_idx = cfg.input_select_code[2:0]; // see (R6)
      n_idx = 3'h0;
    end
    else
    begin
      p_idx = {cfg.input_select_code[1:0], 1'b1}; // see (R5)
      n_idx = {cfg.input_select_code[1:0], 1'b0};
    end
    if (cfg.input_select_code[`AFMC_SEL_SWAP_BIT])
    begin
      p_idx = n_idx; // see (R7)
      n_idx = cfg.input_select_code[`AFMC_SEL_MODE_BIT] ? cfg.input_select_code[2:0]
                                                         : {cfg.input_select_code[1:0], 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_line
      assign pos_vec[gi] = (p_idx == 3'(gi));
      assign neg_vec[gi] = (n_idx == 3'(gi));
    end
  endgenerate

  always_comb
  begin
    mux_next.pos_line = pos_vec; // see (R8)
    mux_next.neg_line = neg_vec;
    mux_next.ref_pos  = cfg.reference_select_bit ? `AFMC_REF_PAIR_HI_P
                                                 : `AFMC_REF_PAIR_LOW_P; // see (R9)
    mux_next.ref_neg  = cfg.reference_select_bit ? `AFMC_REF_PAIR_HI_N
                                                 : `AFMC_REF_PAIR_LOW_N;
    cfg5_next = {busy_next, 1'b0, cfg.input_select_code, cfg.reference_select_bit}; // see (R8)
  end

  // amplifier decode
  always_comb
  begin
    mag2   = (cfg.stage2_offset_code[2:0] > `AFMC_OFF2_MAG_MAX) ? `AFMC_OFF2_MAG_MAX
                                                                : cfg.stage2_offset_code[2:0];
    mag2_w = {1'b0, mag2};
    mag3_w = {1'b0, cfg.stage3_offset_code[5:0]};
    amp_next.mod_enable   = cfg.enable_field[`AFMC_EN_MOD_BIT]; // see (R10)
    amp_next.stage_bypass = ~cfg.enable_field[3:1]; // see (R10)
    amp_next.gain1 = cfg.stage1_gain_bit ? `AFMC_GAIN_TEN : `AFMC_GAIN_ONE; // see (R12)
    unique case (cfg.stage2_gain_code) // see (R13)
      2'b00: amp_next.gain2 = `AFMC_GAIN_ONE;
      2'b01: amp_next.gain2 = `AFMC_GAIN_TWO;
      2'b10: amp_next.gain2 = `AFMC_GAIN_FIVE;
      2'b11: amp_next.gain2 = `AFMC_GAIN_TEN;
    endcase
    amp_next.offset2_fifths = cfg.stage2_offset_code[3] ? 4'(-mag2_w) : mag2_w; // see (R14)
    amp_next.gain3_twelfths = cfg.stage3_gain_code; // see (R15)
    amp_next.offset3_twelfths = cfg.stage3_offset_code[6] ? 7'(-mag3_w) : mag3_w; // see (R16)
    if (!cfg.enable_field[1])
    begin
      amp_next.gain1 = `AFMC_GAIN_ONE;
    end
    if (!cfg.enable_field[2])
    begin
      amp_next.gain2          = `AFMC_GAIN_ONE;
      amp_next.offset2_fifths = 4'sh0;
    end
    if (!cfg.enable_field[3])
    begin
      amp_next.gain3_twelfths   = `AFMC_GAIN3_UNITY;
      amp_next.offset3_twelfths = 7'sh00;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mux_reg  <= '0;
      amp_reg  <= '0;
      cfg5_reg <= `AFMC_CFG5_RST;
    end
    else if (clk_en)
    begin
      mux_reg  <= mux_next;
      amp_reg  <= amp_next;
      cfg5_reg <= cfg5_next;
    end
  end

  assign conv_start           = go_reg;
  assign done_trig            = done_reg;
  assign busy                 = busy_reg;
  assign result               = result_reg;
  assign start_bit_readback   = start_rd_reg;
  assign acq_config_word_five = cfg5_reg;
  assign mux                  = mux_reg;
  assign amp                  = amp_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_done_in_run;
    clk_en && state_reg == afmc_pkg::AFMC_RUN && conv_done;
  endsequence

  sequence s_idle_quiet;
    clk_en && state_reg == afmc_pkg::AFMC_IDLE && !cont_mode && !start_req && !pend_reg;
  endsequence

  a_done_stores: assert property ( // see (R3)
    s_done_in_run |=> done_trig && result == $past(conv_data))
    else $error("result not stored with trigger");
  a_cont_restart: assert property ( // see (R2)
    s_done_in_run ##0 cont_mode |=> busy && conv_start)
    else $error("continuous restart missing");
  a_cont_drop: assert property ( // see (R19)
    s_done_in_run ##0 (!cont_mode && !start_req && !pend_reg) |=> !busy && !conv_start)
    else $error("conversion restarted after mode drop");
  a_req_start: assert property ( // see (R4)
    clk_en && state_reg == afmc_pkg::AFMC_IDLE && start_req |=> busy && conv_start)
    else $error("start request ignored");
  a_idle_hold: assert property ( // see (R1)
    s_idle_quiet |=> !busy && !conv_start)
    else $error("conversion without request");
  a_start_later: assert property ( // see (R17)
    clk_en && state_reg == afmc_pkg::AFMC_RUN && start_req && !conv_done
    ##1 s_done_in_run |=> conv_start && busy)
    else $error("start during conversion lost");
  a_start_zero: assert property ( // see (R17)
    start_bit_readback == 1'b0)
    else $error("start bit read back as one");
  a_busy_state: assert property ( // see (R18)
    $rose(busy) |-> conv_start && acq_config_word_five[7])
    else $error("busy rose without a conversion start");
  a_pair_mode: assert property ( // see (R5)
    clk_en && cfg.input_select_code[4:3] == 2'b00
    |=> mux.pos_line == 8'(8'h02 << {$past(cfg.input_select_code[1:0]), 1'b0})
        && mux.neg_line == 8'(8'h01 << {$past(cfg.input_select_code[1:0]), 1'b0}))
    else $error("pair selection wrong");
  a_common_ref: assert property ( // see (R6) see (R7)
    clk_en && cfg.input_select_code[4:3] == 2'b11
    |=> mux.pos_line == 8'h01
        && mux.neg_line == 8'(8'h01 << $past(cfg.input_select_code[2:0])))
    else $error("swapped common reference wrong");
  a_ref_pair: assert property ( // see (R9)
    clk_en && cfg.reference_select_bit |=> mux.ref_pos == 4'h8 && mux.ref_neg == 4'h4)
    else $error("reference pair wrong");
  a_enable_map: assert property ( // see (R10)
    clk_en |=> amp.mod_enable == $past(cfg.enable_field[0])
               && amp.stage_bypass == ~$past(cfg.enable_field[3:1]))
    else $error("enable mapping wrong");
  a_gain_two: assert property ( // see (R13) see (R12)
    clk_en && cfg.enable_field[2:1] == 2'b11 && cfg.stage2_gain_code == 2'b10
    && cfg.stage1_gain_bit |=> amp.gain2 == 4'h5 && amp.gain1 == 4'hA)
    else $error("stage gain wrong");
  a_offset_sign: assert property ( // see (R14) see (R16)
    clk_en && cfg.enable_field[3:2] == 2'b11 && cfg.stage3_offset_code == 7'h40
    && cfg.stage2_offset_code == 4'hD
    |=> amp.offset3_twelfths == 7'sh00 && amp.offset2_fifths == -4'sd5)
    else $error("offset coding wrong");
endmodule // afmc_ctrl
`default_nettype wire

// ### tb/test_adc_frontend_mode_and_mux_control.sv
// self-checking bench of the acquisition mode and multiplexer control block
`timescale 1ns/100ps
`default_nettype none
module test_adc_frontend_mode_and_mux_control;
  logic                clk_sys   = 1'h0;
  logic                rstn      = 1'h0;
  logic                clk_en    = 1'h1;
  logic                cont_mode = 1'h0;
  logic                start_req = 1'h0;
  logic                conv_done = 1'h0;
  logic [15:0]         conv_data = 16'h0000;
  afmc_pkg::afmc_cfg_t cfg       = '0;
  logic                conv_start;
  logic                done_trig;
  logic                busy;
  logic [15:0]         result;
  logic                start_bit_readback;
  logic [7:0]          acq_config_word_five;
  afmc_pkg::afmc_mux_t mux;
  afmc_pkg::afmc_amp_t amp;
  int                  err_total   = 0;
  int                  check_count = 0;
  int                  cycles      = 0;
  logic [3:0]          gain2_tab [4] = '{4'h1, 4'h2, 4'h5, 4'hA};

  afmc_ctrl DUT (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .cont_mode(cont_mode),
    .start_req(start_req), .conv_done(conv_done), .conv_data(conv_data), .cfg(cfg),
    .conv_start(conv_start), .done_trig(done_trig), .busy(busy), .result(result),
    .start_bit_readback(start_bit_readback), .acq_config_word_five(acq_config_word_five),
    .mux(mux), .amp(amp)
  );

  always #25 clk_sys = ~clk_sys;

  // cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic afmc_pkg::afmc_mux_t exp_mux(input logic [4:0] c, input logic r);
    afmc_pkg::afmc_mux_t m;
    logic [2:0]          p;
    logic [2:0]          n;
    p = c[4] ? c[2:0] : {c[1:0], 1'h1};
    n = c[4] ? 3'h0 : {c[1:0], 1'h0};
    m.pos_line = 8'h01 << (c[3] ? n : p);
    m.neg_line = 8'h01 << (c[3] ? p : n);
    m.ref_pos = r ? 4'h8 : 4'h2;
    m.ref_neg = r ? 4'h4 : 4'h1;
    return m;
  endfunction

  function automatic afmc_pkg::afmc_amp_t exp_amp(input afmc_pkg::afmc_cfg_t c);
    afmc_pkg::afmc_amp_t a;
    logic [2:0]          m2;
    logic [3:0]          e;
    e = c.enable_field;
    m2 = (c.stage2_offset_code[2:0] > 3'h5) ? 3'h5 : c.stage2_offset_code[2:0];
    a.mod_enable = e[0];
    a.stage_bypass = ~e[3:1];
    a.gain1 = (e[1] && c.stage1_gain_bit) ? 4'hA : 4'h1;
    a.gain2 = e[2] ? gain2_tab[c.stage2_gain_code] : 4'h1;
    a.offset2_fifths = !e[2] ? 4'h0 : c.stage2_offset_code[3] ? -{1'h0, m2} : {1'h0, m2};
    a.gain3_twelfths = e[3] ? c.stage3_gain_code : 7'h0C;
    a.offset3_twelfths = !e[3] ? 7'h00 : c.stage3_offset_code[6] ?
                         -{1'h0, c.stage3_offset_code[5:0]} : {1'h0, c.stage3_offset_code[5:0]};
    return a;
  endfunction

  task automatic end_conv(input logic [15:0] d, input logic more);
    conv_done = 1'h1;
    conv_data = d;
    @(negedge clk_sys);
    conv_done = 1'h0;
    conv_data = ~d;
    chk_bit("done_trig", 1'h1, done_trig);
    chk_vec("result", {16'h0000, d}, {16'h0000, result});
    chk_bit("conv_start", more, conv_start);
    chk_bit("busy", more, busy);
  endtask

  task automatic t_reset;
    chk_vec("mux", 32'h0000_0000, {8'h00, mux});
    chk_vec("amp", 32'h0000_0000, {2'h0, amp});
    chk_bit("busy", 1'h0, busy);
    $display("test reset done");
  endtask

  task automatic t_on_request;
    start_req = 1'h1;
    @(negedge clk_sys);
    start_req = 1'h0;
    chk_bit("conv_start", 1'h1, conv_start);
    chk_bit("start_readback", 1'h0, start_bit_readback);
    repeat (3) @(negedge clk_sys);
    chk_bit("conv_start", 1'h0, conv_start);
    chk_bit("busy_field", 1'h1, acq_config_word_five[7]);
    end_conv(16'hA5C3, 1'h0);
    repeat (2) @(negedge clk_sys);
    chk_bit("done_trig", 1'h0, done_trig);
    chk_bit("busy_field", 1'h0, acq_config_word_five[7]);
    chk_bit("conv_start", 1'h0, conv_start);
    $display("test on_request done");
  endtask

  task automatic t_pending;
    start_req = 1'h1;
    @(negedge clk_sys);
    start_req = 1'h0;
    repeat (2) @(negedge clk_sys);
    start_req = 1'h1;
    @(negedge clk_sys);
    start_req = 1'h0;
    chk_bit("conv_start", 1'h0, conv_start);
    end_conv(16'h0F0F, 1'h1);
    start_req = 1'h1;
    @(negedge clk_sys);
    end_conv(16'h3C3C, 1'h1);
    start_req = 1'h0;
    @(negedge clk_sys);
    end_conv(16'hC3C3, 1'h1);
    @(negedge clk_sys);
    end_conv(16'hF00F, 1'h0);
    $display("test pending done");
  endtask

  task automatic t_continuous;
    cont_mode = 1'h1;
    @(negedge clk_sys);
    chk_bit("conv_start", 1'h1, conv_start);
    for (int k = 0; k < 3; k++)
    begin
      repeat (k + 1) @(negedge clk_sys);
      end_conv(16'h1234 + 16'(k), 1'h1);
    end
    @(negedge clk_sys);
    cont_mode = 1'h0;
    repeat (3) @(negedge clk_sys);
    end_conv(16'hBEEF, 1'h0);
    $display("test continuous done");
  endtask

  task automatic t_freeze_and_abort;
    clk_en = 1'h0;
    start_req = 1'h1;
    @(negedge clk_sys);
    start_req = 1'h0;
    @(negedge clk_sys);
    chk_bit("busy", 1'h0, busy);
    clk_en = 1'h1;
    start_req = 1'h1;
    @(negedge clk_sys);
    start_req = 1'h0;
    rstn = 1'h0;
    @(negedge clk_sys);
    rstn = 1'h1;
    chk_bit("busy", 1'h0, busy);
    $display("test freeze_and_abort done");
  endtask

  task automatic t_decode;
    for (int i = 0; i < 128; i++)
    begin
      cfg.input_select_code = 5'(i);
      cfg.reference_select_bit = i[0] ^ i[5];
      cfg.enable_field = 4'(i);
      cfg.stage1_gain_bit = i[6];
      cfg.stage2_gain_code = 2'(i >> 4);
      cfg.stage2_offset_code = 4'(i >> 3);
      cfg.stage3_gain_code = 7'(i);
      cfg.stage3_offset_code = 7'(127 - i);
      @(negedge clk_sys);
      chk_vec("mux", {8'h00, exp_mux(cfg.input_select_code, cfg.reference_select_bit)},
              {8'h00, mux});
      chk_vec("acq_word", {24'h00_0000, 2'h0, cfg.input_select_code, cfg.reference_select_bit},
              {24'h00_0000, acq_config_word_five});
      chk_vec("amp", {2'h0, exp_amp(cfg)}, {2'h0, amp});
    end
    cfg.enable_field = 4'h0;
    @(negedge clk_sys);
    chk_bit("mod_enable", 1'h0, amp.mod_enable);
    chk_vec("bypass", 32'h0000_0007, {29'h0, amp.stage_bypass});
    $display("test decode done");
  endtask

  initial
  begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'h1;
    t_reset();
    t_on_request();
    t_pending();
    t_continuous();
    t_freeze_and_abort();
    t_decode();
    final_report();
  end
endmodule // test_adc_frontend_mode_and_mux_control
`default_nettype wire
